// >>> src/viu_consts.svh
`ifndef VIU_CONSTS_SVH
`define VIU_CONSTS_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define VIU_IDX_REQ     10'h0FA
`define VIU_IDX_MASK    10'h0FB
`define VIU_IDX_PRIO    10'h0F9
`define VIU_IDX_PIN     10'h040
`define VIU_IDX_CFG     10'h041
`define VIU_IDX_ISTAT   10'h042
`define VIU_IDX_IMASK   10'h043
`define VIU_BYTE(i)     ({i, 2'b00})

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define VIU_NREQ        5
`define VIU_EDGE_HI     7
`define VIU_EDGE_LO     6
`define VIU_GEN_BIT     7
`define VIU_CFG_ANALOG  0
`define VIU_ST_VEC      0
`define VIU_ST_WAKE     1
`define VIU_NSTAT       2
`define VIU_REQ_RST     5'h00
`define VIU_MASK_RST    8'h00
`define VIU_PRIO_RST    3'h0
`define VIU_EDGE_RST    2'h0

`endif

// >>> src/viu_pkg.sv
package viu_pkg;
   // Vector fetch sequencer states
   typedef enum logic [4:0] {
      VIU_IDLE = 5'h01,
      VIU_HI   = 5'h02,
      VIU_LO   = 5'h04,
      VIU_CAP  = 5'h08,
      VIU_VEC  = 5'h10
   } viu_state_e;
   typedef logic [4:0] viu_req_t;
   typedef logic [2:0] viu_id_t;
endpackage

// >>> src/viu_req_if.sv
interface viu_req_if;
   import viu_pkg::*;
   viu_req_t pending;
   viu_id_t  prio_sel;
   viu_id_t  grant_id;
   logic     any;
   modport ctrl (output pending, output prio_sel, input grant_id, input any);
   modport prio (input pending, input prio_sel, output grant_id, output any);
endinterface

// >>> src/viu_edge.sv
module viu_edge #(
   parameter int W = 4
) (
   input  wire logic         core_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg;
   logic [W-1:0] lvl_next;

   // Level follows once second and third stages agree
   assign lvl_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & level);

   // Three-stage synchroniser and edge pulses
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= {W{1'b1}};
         s2_reg <= {W{1'b1}};
         s3_reg <= {W{1'b1}};
         level  <= {W{1'b1}};
         rise   <= '0;
         fall   <= '0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level  <= lvl_next;
         rise   <= lvl_next & ~level;
         fall   <= ~lvl_next & level;
      end
   end

   a_edge_no_repeat: assert property (@(posedge core_clk) disable iff (rst)
      (rise != '0) |=> ((rise & $past(rise)) == '0))
      else $error("rise pulse repeated on one bit");
endmodule

// >>> src/viu_prio.sv
module viu_prio (
   viu_req_if.prio rq
);
   import viu_pkg::*;

   // Next request index, wrapping after request four
   function automatic viu_id_t viu_wrap(input viu_id_t i);
      return (i >= 3'h4) ? 3'h0 : 3'(i + 3'h1);
   endfunction

   viu_id_t start_w;
   assign start_w = (rq.prio_sel > 3'h4) ? 3'h0 : rq.prio_sel;

   // Rotating search from the programmed top request
   always_comb begin
      viu_id_t idx;
      idx         = start_w;
      rq.grant_id = 3'h0;
      rq.any      = 1'b0;
      for (int k = 0; k < 5; k++) begin
         if (!rq.any && rq.pending[idx]) begin
            rq.grant_id = idx;
            rq.any      = 1'b1;
         end
         idx = viu_wrap(idx);
      end
   end
endmodule

// >>> src/viu_top.sv
`include "viu_consts.svh"
// How it works
// - Five requests: three port-3 lines, wide and narrow timer.
// - Mask register gates each request plus one global enable bit.
// - Request n vector lives at program bytes 2n and 2n+1.
// - Vector byte pair is read as 16-bit service routine address.
// - Programmable priority encoder picks among pending enabled requests.
// - Grant disables interrupts; core saves state, then branches to vector.
// - Masked requests still latch and read back for polling.
// - Line1 to request two, line2 zero, line3 one, timers three, four.
// - Request register bits 7:6 select edges for requests two and zero.
// - Analog mode routes other wake sources to request one, falling edge.
// - Sources stay live in halt; only enabled request ends halt.
// - Current pin levels of port-3 lines readable apart from latches.
module viu_top
   import viu_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        port3_line1,
   input  wire logic        port3_line2,
   input  wire logic        port3_line3,
   input  wire logic        wake_level,
   input  wire logic        wide_timer,
   input  wire logic        narrow_timer,
   input  wire logic        halt_mode,
   input  wire logic        int_ack,
   input  wire logic        int_return,
   output logic             int_req,
   output logic             halt_wake,
   output logic      [15:0] pm_addr,
   output logic             pm_rd,
   input  wire logic [7:0]  pm_data,
   output logic      [15:0] isr_addr,
   output logic             isr_valid,
   output viu_pkg::viu_id_t isr_id,
   output logic             irq
);
   import viu_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   viu_state_e                st_reg, st_next;
   viu_req_t                  req_reg, req_next;
   logic [1:0]                edge_reg;
   logic [7:0]                mask_reg;
   viu_id_t                   prio_reg;
   logic                      analog_reg;
   logic [`VIU_NSTAT-1:0]     stat_reg, stat_next;
   logic [`VIU_NSTAT-1:0]     imask_reg;
   logic [7:0]                hi_reg;
   viu_id_t                   gid_reg;
   logic                      wake_d_reg;

   // ----------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------
   logic [3:0] pin_lvl, pin_rise, pin_fall;

   // Bit 0 line1, bit 1 line2, bit 2 line3, bit 3 wake sources
   viu_edge #(.W(4)) u_edge (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   ({wake_level, port3_line3, port3_line2, port3_line1}),
      .level    (pin_lvl),
      .rise     (pin_rise),
      .fall     (pin_fall)
   );

   // ----------------------------------------
   // Request sources
   // ----------------------------------------
   logic     sel_r0_rise, sel_r0_fall, sel_r2_rise, sel_r2_fall;
   logic     r1_fall;
   viu_req_t req_set;

   // Edge select decode for requests zero and two
   assign sel_r0_rise = edge_reg[0];
   assign sel_r0_fall = ~edge_reg[0] | edge_reg[1];
   assign sel_r2_rise = edge_reg[1];
   assign sel_r2_fall = ~edge_reg[1] | edge_reg[0];
   assign r1_fall     = analog_reg ? pin_fall[3] : pin_fall[2];

   // Source to request mapping
   assign req_set[0] = (sel_r0_rise & pin_rise[1]) | (sel_r0_fall & pin_fall[1]);
   assign req_set[1] = r1_fall;
   assign req_set[2] = (sel_r2_rise & pin_rise[0]) | (sel_r2_fall & pin_fall[0]);
   assign req_set[3] = wide_timer;
   assign req_set[4] = narrow_timer;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic hit_req, hit_mask, hit_prio, hit_pin, hit_cfg, hit_istat, hit_imask;
   logic mapped, setup, wr_acc;

   assign hit_req   = paddr == `VIU_BYTE(`VIU_IDX_REQ);
   assign hit_mask  = paddr == `VIU_BYTE(`VIU_IDX_MASK);
   assign hit_prio  = paddr == `VIU_BYTE(`VIU_IDX_PRIO);
   assign hit_pin   = paddr == `VIU_BYTE(`VIU_IDX_PIN);
   assign hit_cfg   = paddr == `VIU_BYTE(`VIU_IDX_CFG);
   assign hit_istat = paddr == `VIU_BYTE(`VIU_IDX_ISTAT);
   assign hit_imask = paddr == `VIU_BYTE(`VIU_IDX_IMASK);
   assign mapped    = hit_req | hit_mask | hit_prio | hit_pin | hit_cfg | hit_istat | hit_imask;
   assign setup     = psel & ~penable;
   assign wr_acc    = psel & penable & pwrite & mapped;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~mapped;

   // Read data mux
   logic [7:0] rd_mux;
   assign rd_mux = hit_req   ? {edge_reg, 1'b0, req_reg} :
                   hit_mask  ? mask_reg :
                   hit_prio  ? {5'h00, prio_reg} :
                   hit_pin   ? {4'h0, pin_lvl} :
                   hit_cfg   ? {7'h00, analog_reg} :
                   hit_istat ? {6'h00, stat_reg} :
                   hit_imask ? {6'h00, imask_reg} : 8'h00;

   // Read data captured in setup, valid in the access cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         prdata <= {24'h00_0000, rd_mux};
      end
   end

   // ----------------------------------------
   // Priority and grant
   // ----------------------------------------
   viu_req_if rq ();
   logic      gen, take;

   assign gen         = mask_reg[`VIU_GEN_BIT];
   assign rq.pending  = req_reg & mask_reg[4:0];
   assign rq.prio_sel = prio_reg;

   viu_prio u_prio (
      .rq (rq)
   );

   // Request to core only while idle, enabled and pending
   assign int_req   = (st_reg == VIU_IDLE) & gen & rq.any;
   assign take      = int_req & int_ack;
   assign halt_wake = halt_mode & gen & rq.any;

   // ----------------------------------------
   // Request latch
   // ----------------------------------------
   // Software write, grant clear, then hardware set wins
   always_comb begin
      req_next = req_reg;
      if (wr_acc && hit_req) begin
         req_next = pwdata[4:0];
      end
      if (take) begin
         req_next[rq.grant_id] = 1'b0;
      end
      req_next = req_next | req_set;
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         req_reg    <= `VIU_REQ_RST;
         edge_reg   <= `VIU_EDGE_RST;
         prio_reg   <= `VIU_PRIO_RST;
         analog_reg <= 1'b0;
         imask_reg  <= '0;
      end else begin
         req_reg <= req_next;
         if (wr_acc && hit_req) begin
            edge_reg <= pwdata[`VIU_EDGE_HI:`VIU_EDGE_LO];
         end
         if (wr_acc && hit_prio) begin
            prio_reg <= pwdata[2:0];
         end
         if (wr_acc && hit_cfg) begin
            analog_reg <= pwdata[`VIU_CFG_ANALOG];
         end
         if (wr_acc && hit_imask) begin
            imask_reg <= pwdata[`VIU_NSTAT-1:0];
         end
      end
   end

   // Mask register; grant drops global enable, return restores it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mask_reg <= `VIU_MASK_RST;
      end else if (take) begin
         mask_reg[`VIU_GEN_BIT] <= 1'b0;
      end else if (wr_acc && hit_mask) begin
         mask_reg <= {pwdata[7], 2'b00, pwdata[4:0]};
      end else if (int_return) begin
         mask_reg[`VIU_GEN_BIT] <= 1'b1;
      end
   end

   // ----------------------------------------
   // Vector fetch sequencer
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         VIU_IDLE: if (take) st_next = VIU_HI;
         VIU_HI:   st_next = VIU_LO;
         VIU_LO:   st_next = VIU_CAP;
         VIU_CAP:  st_next = VIU_VEC;
         VIU_VEC:  st_next = VIU_IDLE;
         default:  st_next = VIU_IDLE;
      endcase
   end

   // Vector location is twice the request number
   assign pm_rd   = (st_reg == VIU_HI) | (st_reg == VIU_LO);
   assign pm_addr = {12'h000, gid_reg, (st_reg == VIU_LO)};
   assign isr_valid = (st_reg == VIU_VEC);
   assign isr_id    = gid_reg;

   // Sequencer state, granted id and address bytes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg   <= VIU_IDLE;
         gid_reg  <= 3'h0;
         hi_reg   <= 8'h00;
         isr_addr <= 16'h0000;
      end else begin
         st_reg <= st_next;
         if (take) begin
            gid_reg <= rq.grant_id;
         end
         if (st_reg == VIU_LO) begin
            hi_reg <= pm_data;
         end
         if (st_reg == VIU_CAP) begin
            isr_addr <= {hi_reg, pm_data};
         end
      end
   end

   // ----------------------------------------
   // Event status and interrupt output
   // ----------------------------------------
   logic [`VIU_NSTAT-1:0] ev;

   assign ev[`VIU_ST_VEC]  = isr_valid;
   assign ev[`VIU_ST_WAKE] = halt_wake & ~wake_d_reg;

   // Write one clears, new event wins
   always_comb begin
      stat_next = stat_reg;
      if (wr_acc && hit_istat) begin
         stat_next = stat_reg & ~pwdata[`VIU_NSTAT-1:0];
      end
      stat_next = stat_next | ev;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stat_reg   <= '0;
         wake_d_reg <= 1'b0;
      end else begin
         stat_reg   <= stat_next;
         wake_d_reg <= halt_wake;
      end
   end

   assign irq = |(stat_reg & imask_reg);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_req_gated: assert property (@(posedge core_clk) disable iff (rst)
      int_req |-> (gen && ((req_reg & mask_reg[4:0]) != 5'h00)))
      else $error("request raised without enabled pending bit");

   a_grant_disables: assert property (@(posedge core_clk) disable iff (rst)
      take |=> (!gen && st_reg == VIU_HI) ##1 (!int_req)[*3])
      else $error("grant left interrupts enabled");

   a_grant_clears: assert property (@(posedge core_clk) disable iff (rst)
      (take && !req_set[rq.grant_id]) |=> !req_reg[gid_reg])
      else $error("granted request bit not cleared");

   a_vec_location: assert property (@(posedge core_clk) disable iff (rst)
      pm_rd |-> (pm_addr[15:1] == {12'h000, gid_reg}))
      else $error("wrong vector location");

   a_vec_pair: assert property (@(posedge core_clk) disable iff (rst)
      isr_valid |-> (isr_addr == {$past(pm_data, 2), $past(pm_data, 1)}))
      else $error("service address not built from byte pair");

   a_poll_latched: assert property (@(posedge core_clk) disable iff (rst)
      (req_set != 5'h00) |=> ((req_reg & $past(req_set)) == $past(req_set)))
      else $error("request event not latched");

   a_line3_falls: assert property (@(posedge core_clk) disable iff (rst)
      (!analog_reg && pin_fall[2]) |=> req_reg[1])
      else $error("line three fall did not set request one");

   a_halt_exit: assert property (@(posedge core_clk) disable iff (rst)
      halt_wake |-> (halt_mode && mask_reg[`VIU_GEN_BIT] && ((req_reg & mask_reg[4:0]) != 5'h00)))
      else $error("halt ended without enabled request");

   a_prio_pick_pending: assert property (@(posedge core_clk) disable iff (rst)
      (rq.pending != 5'h00) |-> (rq.any && rq.pending[rq.grant_id]
         && (prio_reg > 3'h4 || !rq.pending[prio_reg] || rq.grant_id == prio_reg)))
      else $error("priority pick is not the top pending request");

   a_fetch_len: assert property (@(posedge core_clk) disable iff (rst)
      take |-> ##4 isr_valid)
      else $error("vector not delivered in four cycles");
endmodule

// >>> testbench/viu_core_model.sv
// ----------------------------------------
// Core side: acks, vector fetch, return
// ----------------------------------------
module viu_core_model (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        int_req,
   input  wire logic        pm_rd,
   input  wire logic [15:0] pm_addr,
   input  wire logic        isr_valid,
   input  wire logic        ack_en,
   input  wire logic        ret_go,
   output logic             int_ack,
   output logic             int_return,
   output logic      [7:0]  pm_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic busy_reg;

   // One ack per grant, return only on command
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         int_ack    <= 1'b0;
         int_return <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         int_ack    <= ack_en & int_req & ~int_ack & ~busy_reg;
         int_return <= ret_go;
         busy_reg   <= (busy_reg | int_ack) & ~isr_valid;
      end
   end

   // Program memory, one cycle late; scrambles when idle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pm_data <= 8'h00;
      end else if (pm_rd) begin
         pm_data <= 8'hA0 + pm_addr[7:0];
      end else begin
         pm_data <= ~pm_data;
      end
   end
endmodule

// >>> testbench/vectored_interrupt_unit_tb.sv
`include "viu_consts.svh"
module vectored_interrupt_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import viu_pkg::*;

   localparam logic [11:0] A_REQ  = `VIU_BYTE(`VIU_IDX_REQ);
   localparam logic [11:0] A_MASK = `VIU_BYTE(`VIU_IDX_MASK);
   localparam logic [11:0] A_PRIO = `VIU_BYTE(`VIU_IDX_PRIO);
   localparam logic [11:0] A_PIN  = `VIU_BYTE(`VIU_IDX_PIN);
   localparam logic [11:0] A_CFG  = `VIU_BYTE(`VIU_IDX_CFG);
   localparam logic [11:0] A_ST   = `VIU_BYTE(`VIU_IDX_ISTAT);
   localparam logic [11:0] A_IM   = `VIU_BYTE(`VIU_IDX_IMASK);

   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr;
   logic        l1 = 1'b1, l2 = 1'b1, l3 = 1'b1, wk = 1'b1;
   logic        wide_timer = 1'b0, narrow_timer = 1'b0, halt_mode = 1'b0;
   logic        ack_en = 1'b0, ret_go = 1'b0;
   logic        int_ack, int_return, int_req, halt_wake, pm_rd, isr_valid, irq;
   logic [15:0] pm_addr, isr_addr;
   logic [7:0]  pm_data, vb;
   viu_id_t     isr_id;
   logic [31:0] rd;
   logic        er, seen;
   logic [1:0]  ec;
   int          n_fail = 0, tests_run = 0, cyc = 0;

   viu_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port3_line1(l1), .port3_line2(l2), .port3_line3(l3), .wake_level(wk),
      .wide_timer(wide_timer), .narrow_timer(narrow_timer), .halt_mode(halt_mode),
      .int_ack(int_ack), .int_return(int_return), .int_req(int_req), .halt_wake(halt_wake),
      .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data), .isr_addr(isr_addr),
      .isr_valid(isr_valid), .isr_id(isr_id), .irq(irq));

   viu_core_model core (.core_clk(core_clk), .rst(rst), .int_req(int_req), .pm_rd(pm_rd),
      .pm_addr(pm_addr), .isr_valid(isr_valid), .ack_en(ack_en), .ret_go(ret_go),
      .int_ack(int_ack), .int_return(int_return), .pm_data(pm_data));

   // ----------------------------------------
   // Clock, timeout, closing report
   // ----------------------------------------
   initial begin
      forever #2 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Compare, bus and stimulus tasks
   // ----------------------------------------
   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", nm, e, s);
      end
   endtask

   task automatic chk_addr(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Setup then access; hold until pready sampled high
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
      @(negedge core_clk); // Let the written register settle before checks
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(a, 1'b0, 32'h0);
      chk_reg(nm, e, rd);
   endtask

   task automatic pins(input logic a, input logic b, input logic c, input logic w);
      @(posedge core_clk);
      l1 <= a;
      l2 <= b;
      l3 <= c;
      wk <= w;
      repeat (8) @(posedge core_clk);
   endtask

   task automatic pulse(input logic wide);
      @(posedge core_clk);
      wide_timer   <= wide;
      narrow_timer <= ~wide;
      @(posedge core_clk);
      wide_timer   <= 1'b0;
      narrow_timer <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic wait_isr();
      seen = 1'b0;
      for (int n = 0; n < 40 && !seen; n++) begin
         @(posedge core_clk);
         seen = (isr_valid === 1'b1);
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      rdc(A_REQ, 32'h0, "req reset");
      rdc(A_MASK, 32'h0, "mask reset");
      rdc(A_PIN, 32'hF, "pin idle");
      wr(12'h200, 32'hFF);
      apb(12'h200, 1'b0, 32'h0);
      chk_bit("unmapped err", 1'b1, er);
      chk_reg("unmapped data", 32'h0, rd);
      $display("test reset done");

      pulse(1'b0);
      rdc(A_REQ, 32'h10, "narrow timer");
      pulse(1'b1);
      rdc(A_REQ, 32'h18, "wide timer");
      chk_bit("masked int_req", 1'b0, int_req);
      pins(1'b1, 1'b1, 1'b0, 1'b1);
      rdc(A_REQ, 32'h1A, "line3 fall");
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      rdc(A_REQ, 32'h1A, "line3 rise");
      wr(A_CFG, 32'h1);
      wr(A_REQ, 32'h0);
      pins(1'b1, 1'b1, 1'b1, 1'b0);
      rdc(A_REQ, 32'h02, "wake fall");
      pins(1'b1, 1'b1, 1'b1, 1'b1);
      wr(A_CFG, 32'h0);
      $display("test sources done");

      for (int i = 0; i < 4; i++) begin
         ec = 2'(i);
         wr(A_REQ, {24'h0, ec, 6'h00});
         pins(1'b0, 1'b0, 1'b1, 1'b1);
         rdc(A_PIN, 32'hC, "pin low");
         rdc(A_REQ, {24'h0, ec, 3'b000, ~ec[1] | ec[0], 1'b0, ~ec[0] | ec[1]}, "fall");
         wr(A_REQ, {24'h0, ec, 6'h00});
         pins(1'b1, 1'b1, 1'b1, 1'b1);
         rdc(A_REQ, {24'h0, ec, 3'b000, ec[1], 1'b0, ec[0]}, "rise");
      end
      $display("test edges done");

      wr(A_REQ, 32'h0);
      wr(A_MASK, 32'h9F);
      for (int p = 0; p < 5; p++) begin
         wr(A_PRIO, 32'(p));
         wr(A_REQ, 32'h1F);
         @(posedge core_clk);
         ack_en <= 1'b1;
         wait_isr();
         ack_en <= 1'b0;
         vb = 8'hA0 + 8'(2 * p);
         chk_bit("isr seen", 1'b1, seen);
         chk_reg("isr id", 32'(p), 32'(isr_id));
         chk_addr("vector", {vb, vb + 8'h01}, isr_addr);
         chk_bit("req after grant", 1'b0, int_req);
         rdc(A_REQ, 32'h1F & ~(32'h1 << p), "req clr");
         rdc(A_MASK, 32'h1F, "global off");
         @(posedge core_clk);
         ret_go <= 1'b1;
         @(posedge core_clk);
         ret_go <= 1'b0;
         repeat (3) @(posedge core_clk);
         rdc(A_MASK, 32'h9F, "global on");
      end
      $display("test vectors done");

      wr(A_MASK, 32'h80);
      chk_bit("no unmasked", 1'b0, int_req);
      wr(A_MASK, 32'h1F);
      chk_bit("global off", 1'b0, int_req);
      wr(A_MASK, 32'h81);
      chk_bit("enabled", 1'b1, int_req);
      rdc(A_REQ, 32'h0F, "polled");
      rdc(A_ST, 32'h1, "status");
      chk_bit("irq masked", 1'b0, irq);
      wr(A_IM, 32'h1);
      chk_bit("irq on", 1'b1, irq);
      wr(A_ST, 32'h1);
      chk_bit("irq cleared", 1'b0, irq);
      $display("test masks done");

      wr(A_MASK, 32'h0);
      wr(A_REQ, 32'h0);
      @(posedge core_clk);
      halt_mode <= 1'b1;
      pulse(1'b0);
      chk_bit("halt masked", 1'b0, halt_wake);
      rdc(A_REQ, 32'h10, "halt source");
      wr(A_MASK, 32'h90);
      chk_bit("halt wake", 1'b1, halt_wake);
      rdc(A_ST, 32'h2, "wake status");
      @(posedge core_clk);
      halt_mode <= 1'b0;
      $display("test halt done");
      end_sim();
   end
endmodule
